// >>> logic/wlu_pkg.sv
/*
 * Package of the word logic unit: function codes, flag layout, operand path
 * constants and the request and answer carriers.
 * Assumes a single 20 MHz core clock shared by every user of the package.
 */
package wlu_pkg;

	// ************************************************************
	// Widths and function codes
	// ************************************************************
	localparam int WORD_W = 16;
	localparam int FUNC_W = 6;
	localparam logic [FUNC_W-1:0] FUNC_INVERT = 6'h1D;
	localparam logic [FUNC_W-1:0] FUNC_AND = 6'h22;
	localparam logic [FUNC_W-1:0] FUNC_OR = 6'h23;
	localparam logic [FUNC_W-1:0] FUNC_XOR = 6'h24;
	localparam logic [FUNC_W-1:0] FUNC_XNOR = 6'h25;

	// ************************************************************
	// Data memory pointer checks
	// ************************************************************
	localparam int DM_ADDR_W = 14;
	// Last data memory word, 1999 in decimal; a pointer past it names no word.
	localparam logic [DM_ADDR_W-1:0] DM_LAST_ADDR = 14'h07CF;
	localparam int BCD_DIGITS = 4;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;

	// ************************************************************
	// Reset values and timing
	// ************************************************************
	localparam logic [WORD_W-1:0] RESULT_RESET = 16'h0000;
	localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;
	localparam logic FLAG_RESET = 1'b0;
	localparam int CLK_PERIOD_NS = 50;
	localparam int EXEC_LATENCY = 1;

	// One operand as the fetch stage hands it over.
	typedef struct packed {
		logic indirect;
		logic [WORD_W-1:0] pointer;
		logic [WORD_W-1:0] value;
	} wlu_operand_t;

	typedef struct packed {
		logic cond;
		logic [FUNC_W-1:0] func;
		wlu_operand_t first;
		wlu_operand_t second;
		logic [WORD_W-1:0] dest_old;
	} wlu_req_t;

	typedef struct packed {
		logic [WORD_W-1:0] result;
		logic write;
		logic zero_flag;
		logic error_flag;
	} wlu_ans_t;

endpackage

// >>> logic/wlu_ptr_check.sv
/*
 * Checks one indirect data memory pointer word: its content must be BCD
 * and the decimal address it names must fall inside the data memory area.
 * Assumes a pointer that is combinationally stable in the request cycle.
 */
module wlu_ptr_check
#(
	parameter int WORD_W = 16,
	parameter logic [13:0] LAST_ADDR = 14'h07CF
)
(
	input wire logic indirect_in,
	input wire logic [WORD_W-1:0] pointer_in,
	output logic bad_out
);
	// Four decimal digits can name no address above 9999.
	if (WORD_W != wlu_pkg::BCD_DIGITS * 4 || LAST_ADDR > 14'h270F)
	begin : g_param_check
		$error("pointer word must hold four BCD digits and the last address at most 9999");
	end

	logic [3:0] dig [wlu_pkg::BCD_DIGITS];
	logic [wlu_pkg::BCD_DIGITS-1:0] dig_bad;
	logic [13:0] dec_addr;
	logic not_bcd;
	logic past_end;

	genvar g;
	generate
		for (g = 0; g < wlu_pkg::BCD_DIGITS; g++)
		begin : g_dig
			assign dig[g] = pointer_in[4*g +: 4];
			assign dig_bad[g] = dig[g] > wlu_pkg::BCD_MAX_DIGIT;
		end
	endgenerate

	// Each digit is widened first, so no product can wrap before the sum.
	assign dec_addr = 14'(dig[3]) * 14'h03E8 + 14'(dig[2]) * 14'h0064
		+ 14'(dig[1]) * 14'h000A + 14'(dig[0]);
	assign not_bcd = |dig_bad;
	assign past_end = dec_addr > LAST_ADDR;
	assign bad_out = indirect_in & (not_bcd | past_end);
endmodule

// >>> logic/wlu_top.sv
/*
 * Word logic unit: executes the complement, AND, OR, XOR and XNOR word
 * instructions, one per cycle, with registered result and flags.
 * Assumes the operand fetch stage delivers operand values and pointer words
 * in the request cycle and writes back the result when write is high.
 */
// Operation
// - Execution condition off: no operation, result and flags keep their values.
// - Complement inverts every bit of the operand word.
// - Word AND gives bitwise AND of both input words.
// - Word OR gives bitwise inclusive OR of both input words.
// - Word XOR gives bitwise exclusive OR of both input words.
// - Word XNOR gives bitwise inverted XOR of both input words.
// - Zero flag set when the written 16-bit result is zero, else cleared.
// - Error flag when an indirect pointer reaches a nonexistent word.
// - Error flag when pointer is not BCD or beyond area end.
module wlu_top
(
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RESET_IN,
	// Instruction request
	input wire wlu_pkg::wlu_req_t REQ_IN,
	// Answer
	output wlu_pkg::wlu_ans_t ANS_OUT
);
	// ************************************************************
	// Operand checks
	// ************************************************************
	logic first_bad;
	logic second_bad;
	logic is_inv;
	logic is_two;
	logic valid_func;

	wlu_ptr_check #(
		.WORD_W(wlu_pkg::WORD_W),
		.LAST_ADDR(wlu_pkg::DM_LAST_ADDR)
	) u_chk_first (
		.indirect_in(REQ_IN.first.indirect),
		.pointer_in(REQ_IN.first.pointer),
		.bad_out(first_bad)
	);

	wlu_ptr_check #(
		.WORD_W(wlu_pkg::WORD_W),
		.LAST_ADDR(wlu_pkg::DM_LAST_ADDR)
	) u_chk_second (
		.indirect_in(REQ_IN.second.indirect),
		.pointer_in(REQ_IN.second.pointer),
		.bad_out(second_bad)
	);

	assign is_inv = REQ_IN.func == wlu_pkg::FUNC_INVERT;
	assign is_two = REQ_IN.func == wlu_pkg::FUNC_AND || REQ_IN.func == wlu_pkg::FUNC_OR
		|| REQ_IN.func == wlu_pkg::FUNC_XOR || REQ_IN.func == wlu_pkg::FUNC_XNOR;
	assign valid_func = is_inv | is_two;

	// ************************************************************
	// Function select
	// ************************************************************
	logic [15:0] a;
	logic [15:0] b;
	logic [15:0] logic_out;
	logic exec;
	logic err;
	logic next_write;
	logic [15:0] next_result;

	assign a = REQ_IN.first.value;
	assign b = REQ_IN.second.value;

	always_comb
	begin
		case (REQ_IN.func)
			wlu_pkg::FUNC_INVERT: logic_out = ~a;
			wlu_pkg::FUNC_AND: logic_out = a & b;
			wlu_pkg::FUNC_OR: logic_out = a | b;
			wlu_pkg::FUNC_XOR: logic_out = a ^ b;
			wlu_pkg::FUNC_XNOR: logic_out = ~(a ^ b);
			default: logic_out = a;
		endcase
	end

	assign exec = REQ_IN.cond & valid_func;
	// The complement has one operand, so the second pointer is ignored for it.
	// indirect error
	assign err = first_bad | (is_two & second_bad);
	assign next_write = exec & ~err;
	assign next_result = next_write ? logic_out : REQ_IN.dest_old;

	// ************************************************************
	// Answer registers
	// ************************************************************
	always_ff @(posedge CORE_CLK_IN)
	begin
		if (RESET_IN)
		begin
			ANS_OUT.result <= wlu_pkg::RESULT_RESET;
			ANS_OUT.write <= 1'b0;
			ANS_OUT.zero_flag <= wlu_pkg::FLAG_RESET;
			ANS_OUT.error_flag <= wlu_pkg::FLAG_RESET;
		end
		else
		begin
			ANS_OUT.write <= next_write;
			if (exec)
			begin
				ANS_OUT.result <= next_result;
				ANS_OUT.error_flag <= err;
				if (!err)
					ANS_OUT.zero_flag <= logic_out == wlu_pkg::ZERO_WORD;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	// The digit tests are written out again so the checks do not lean on the checker.
	logic first_nibble_bad;
	logic second_nibble_bad;

	assign first_nibble_bad = REQ_IN.first.pointer[3:0] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.first.pointer[7:4] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.first.pointer[11:8] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.first.pointer[15:12] > wlu_pkg::BCD_MAX_DIGIT;
	assign second_nibble_bad = REQ_IN.second.pointer[3:0] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.second.pointer[7:4] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.second.pointer[11:8] > wlu_pkg::BCD_MAX_DIGIT
		|| REQ_IN.second.pointer[15:12] > wlu_pkg::BCD_MAX_DIGIT;

	property p_idle_hold;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		!exec |=> $stable(ANS_OUT.result) && $stable(ANS_OUT.zero_flag)
			&& $stable(ANS_OUT.error_flag) && !ANS_OUT.write;
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("idle changed answer");

	property p_inv;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err && is_inv |=> ANS_OUT.result == ~$past(a);
	endproperty
	a_inv: assert property (p_inv) else $error("complement wrong");

	property p_and;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err && REQ_IN.func == wlu_pkg::FUNC_AND |=> ANS_OUT.result == ($past(a) & $past(b));
	endproperty
	a_and: assert property (p_and) else $error("and wrong");

	property p_or;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err && REQ_IN.func == wlu_pkg::FUNC_OR |=> ANS_OUT.result == ($past(a) | $past(b));
	endproperty
	a_or: assert property (p_or) else $error("or wrong");

	property p_xor;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err && REQ_IN.func == wlu_pkg::FUNC_XOR |=> ANS_OUT.result == ($past(a) ^ $past(b));
	endproperty
	a_xor: assert property (p_xor) else $error("xor wrong");

	property p_xnor;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err && REQ_IN.func == wlu_pkg::FUNC_XNOR
			|=> ANS_OUT.result == ~($past(a) ^ $past(b));
	endproperty
	a_xnor: assert property (p_xnor) else $error("xnor wrong");

	property p_zero;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		ANS_OUT.write |-> ANS_OUT.zero_flag == (ANS_OUT.result == wlu_pkg::ZERO_WORD);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");

	property p_err;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && REQ_IN.first.indirect && first_bad |=> ANS_OUT.error_flag && !ANS_OUT.write;
	endproperty
	a_err: assert property (p_err) else $error("error flag missed");

	property p_bcd;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && REQ_IN.first.indirect && first_nibble_bad
			|=> ANS_OUT.error_flag && !ANS_OUT.write;
	endproperty
	a_bcd: assert property (p_bcd) else $error("non BCD pointer accepted");

	property p_bcd_second;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && is_two && REQ_IN.second.indirect && second_nibble_bad
			|=> ANS_OUT.error_flag && !ANS_OUT.write;
	endproperty
	a_bcd_second: assert property (p_bcd_second) else $error("non BCD second pointer accepted");

	// A good instruction writes and clears an error left by an earlier one.
	property p_clear;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && !err |=> ANS_OUT.write && !ANS_OUT.error_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("good instruction not written");

	// No result was produced on an error, so the zero flag keeps its meaning.
	property p_zero_keep;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && err |=> $stable(ANS_OUT.zero_flag);
	endproperty
	a_zero_keep: assert property (p_zero_keep) else $error("zero flag changed on error");

	property p_keep;
		@(posedge CORE_CLK_IN) disable iff (RESET_IN)
		exec && err |=> ANS_OUT.result == $past(REQ_IN.dest_old) && !ANS_OUT.write;
	endproperty
	a_keep: assert property (p_keep) else $error("destination overwritten on error");

	c_xnor: cover property (@(posedge CORE_CLK_IN) exec && REQ_IN.func == wlu_pkg::FUNC_XNOR);
	c_zero: cover property (@(posedge CORE_CLK_IN) ANS_OUT.write && ANS_OUT.zero_flag);
	c_err: cover property (@(posedge CORE_CLK_IN) exec && err);
	c_idle: cover property (@(posedge CORE_CLK_IN) !REQ_IN.cond ##1 exec);
endmodule

// >>> sim/test_word_logic_unit.sv
/*
 * Self-checking bench of the word logic unit: drives requests straight into
 * wlu_top and judges each registered answer one edge later.
 * Assumes the single core clock, a synchronous active-high reset and that
 * the result and flags stand until the next executed instruction.
 */
module test_word_logic_unit;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Clock, reset and the unit under test
	// ************************************************************
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	wlu_pkg::wlu_req_t req = '0;
	wlu_pkg::wlu_ans_t ans;
	int fail_count = 0;
	int comparisons = 0;

	always #(wlu_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

	wlu_top u_dut
	(
		.CORE_CLK_IN(core_clk),
		.RESET_IN(reset),
		.REQ_IN(req),
		.ANS_OUT(ans)
	);

	// ************************************************************
	// Shared helpers
	// ************************************************************
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
			fail_count++;
		end
	endtask

	task automatic expect_ans(input logic [15:0] res, input logic wr, input logic zf,
		input logic ef);
		chk("result", res, ans.result);
		chk("write", {15'h0000, wr}, {15'h0000, ans.write});
		chk("zero_flag", {15'h0000, zf}, {15'h0000, ans.zero_flag});
		chk("error_flag", {15'h0000, ef}, {15'h0000, ans.error_flag});
	endtask

	// Direct operands; the old destination is a marker that no good result gives.
	function automatic wlu_pkg::wlu_req_t mk(input logic [5:0] func, input logic [15:0] a,
		input logic [15:0] b);
		mk = '0;
		mk.cond = 1'b1;
		mk.func = func;
		mk.first.value = a;
		mk.second.value = b;
		mk.dest_old = 16'hA5A5;
	endfunction

	// The request stands for exactly one sampling edge, then the bus idles.
	task automatic exec(input wlu_pkg::wlu_req_t r);
		@(posedge core_clk);
		req <= r;
		@(posedge core_clk);
		req <= '0;
		#1;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic check_ops();
		exec(mk(wlu_pkg::FUNC_INVERT, 16'h00FF, 16'h1234));
		expect_ans(16'hFF00, 1'b1, 1'b0, 1'b0);
		exec(mk(wlu_pkg::FUNC_INVERT, 16'hFFFF, 16'h0000));
		expect_ans(16'h0000, 1'b1, 1'b1, 1'b0);
		exec(mk(wlu_pkg::FUNC_AND, 16'hF0F0, 16'h0FF0));
		expect_ans(16'h00F0, 1'b1, 1'b0, 1'b0);
		exec(mk(wlu_pkg::FUNC_OR, 16'hF000, 16'h000F));
		expect_ans(16'hF00F, 1'b1, 1'b0, 1'b0);
		exec(mk(wlu_pkg::FUNC_XOR, 16'hFF00, 16'h0FF0));
		expect_ans(16'hF0F0, 1'b1, 1'b0, 1'b0);
		exec(mk(wlu_pkg::FUNC_XOR, 16'h5A5A, 16'h5A5A));
		expect_ans(16'h0000, 1'b1, 1'b1, 1'b0);
		exec(mk(wlu_pkg::FUNC_XNOR, 16'hFF00, 16'h0FF0));
		expect_ans(16'h0F0F, 1'b1, 1'b0, 1'b0);
		exec(mk(wlu_pkg::FUNC_XNOR, 16'h1234, 16'hEDCB));
		expect_ans(16'h0000, 1'b1, 1'b1, 1'b0);
		@(posedge core_clk);
		#1;
		expect_ans(16'h0000, 1'b0, 1'b1, 1'b0);
	endtask

	task automatic check_cond_off();
		wlu_pkg::wlu_req_t r;
		r = mk(wlu_pkg::FUNC_OR, 16'h1111, 16'h2222);
		r.cond = 1'b0;
		exec(r);
		expect_ans(16'h0000, 1'b0, 1'b1, 1'b0);
		exec(mk(6'h26, 16'h1111, 16'h2222));
		expect_ans(16'h0000, 1'b0, 1'b1, 1'b0);
	endtask

	task automatic check_errors();
		wlu_pkg::wlu_req_t r;
		r = mk(wlu_pkg::FUNC_AND, 16'hFFFF, 16'hFFFF);
		r.first.indirect = 1'b1;
		r.first.pointer = 16'h00A0;
		exec(r);
		expect_ans(16'hA5A5, 1'b0, 1'b1, 1'b1);
		exec(mk(wlu_pkg::FUNC_AND, 16'hF0F0, 16'h0FF0));
		expect_ans(16'h00F0, 1'b1, 1'b0, 1'b0);
		r = mk(wlu_pkg::FUNC_OR, 16'h0001, 16'h0002);
		r.second.indirect = 1'b1;
		r.second.pointer = 16'h9999;
		exec(r);
		expect_ans(16'hA5A5, 1'b0, 1'b0, 1'b1);
		r.second.pointer = 16'h0100;
		exec(r);
		expect_ans(16'h0003, 1'b1, 1'b0, 1'b0);
		r.second.pointer = 16'h1999;
		exec(r);
		expect_ans(16'h0003, 1'b1, 1'b0, 1'b0);
		r.second.pointer = 16'h2000;
		exec(r);
		expect_ans(16'hA5A5, 1'b0, 1'b0, 1'b1);
		r.second.pointer = 16'h0A00;
		exec(r);
		expect_ans(16'hA5A5, 1'b0, 1'b0, 1'b1);
		r = mk(wlu_pkg::FUNC_INVERT, 16'h0F0F, 16'h0000);
		r.second.indirect = 1'b1;
		r.second.pointer = 16'h00A0;
		exec(r);
		expect_ans(16'hF0F0, 1'b1, 1'b0, 1'b0);
	endtask

	// ************************************************************
	// Verdict and main sequence
	// ************************************************************
	task automatic results();
		if (fail_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		#1;
		expect_ans(16'h0000, 1'b0, 1'b0, 1'b0);
		check_ops();
		check_cond_off();
		check_errors();
		results();
	end
endmodule
